// >>> tb/phase_engine_model.sv
// Purpose: Stand-in bus phase engine taking one step at a time
// Assumes: Step handshake of the sequencer
// Notes:   lat sets cycles from take to done
`timescale 1ns/10ps
module phase_engine_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Step side
  input  wire logic       step_valid,
  output logic            step_ready,
  output logic            step_done,
  output logic [7:0]      step_rx_byte,
  // Pace
  input  wire logic [3:0] lat
);
  logic [3:0] cnt_r;
  logic       out_r;
  // ==================
  // Engine
  // Ready only while nothing is outstanding
  assign step_ready = !out_r && !rst;
  always_ff @(posedge clk)
  begin
    step_done <= 1'b0;
    step_rx_byte <= step_rx_byte + 8'h5B; // Never holds a stale byte
    if (rst)
    begin
      out_r <= 1'b0;
      step_rx_byte <= 8'h00;
    end
    else if (step_valid && step_ready)
    begin
      out_r <= 1'b1;
      cnt_r <= lat;
    end
    else if (out_r && cnt_r == 4'h0)
    begin
      out_r <= 1'b0;
      step_done <= 1'b1;
    end
    else if (out_r)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule

// >>> tb/scsi_target_command_sequencer_tb.sv
// Purpose: Self-checking bench of the target command sequencer
// Assumes: Engine model answers each step after a random delay
// Notes:   Steps are compared in order of issue
`timescale 1ns/10ps
module scsi_target_command_sequencer_tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cv = 1'b0;
  logic [7:0]         cc = 8'h00, co = 8'h00, cnt = 8'h02, rd = 8'h00, c, a;
  logic [2:0]         peer = 3'h0;
  logic [3:0]         lat = 4'h0;
  logic               re, we, sv, sr, sdn, busy, done, rej, rdy;
  logic [7:0]         ra, wa, wd, rxb, last_rx, rx_exp;
  seq_pkg::bus_step_t sdat, got, exp;
  seq_pkg::bus_step_t q[$];
  logic [7:0]         sbuf [256];
  logic [7:0]         codes [13] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
                                     8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C};
  int                 err_total = 0, tests_run = 0, seed = 15696, n, m;
  logic               tail, disc, cdb = 1'b0;
  // ==================
  // Design, engine and send buffer
  always #20 clk = ~clk;
  target_cmd_sequencer #(.AW(8), .CW(8)) uut (.clk(clk), .rst(rst), .cmd_valid(cv), .cmd_code(cc),
    .cmd_operand(co), .cmd_ready(rdy), .transfer_byte_count(cnt), .peer_id_select(peer), .sbuf_rd_en(re),
    .sbuf_rd_addr(ra), .sbuf_rd_data(rd), .rx_wr_en(we), .rx_wr_addr(wa), .rx_wr_data(wd), .step_valid(sv),
    .step_data(sdat), .step_ready(sr), .step_done(sdn), .step_rx_byte(rxb), .busy(busy), .cmd_done(done),
    .cmd_reject(rej));
  phase_engine_model eng (.clk(clk), .rst(rst), .step_valid(sv), .step_ready(sr), .step_done(sdn),
    .step_rx_byte(rxb), .lat(lat));
  always @(posedge clk)
    if (re) rd <= sbuf[ra];
  task automatic chk(input logic [17:0] g, input logic [17:0] w);
    tests_run++;
    if (g !== w)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, w);
    end
  endtask
  task automatic op(seq_pkg::op_kind_t k, seq_pkg::phase_t p, logic [7:0] d);
    q.push_back({k, p, peer, d});
  endtask
  task automatic sd(int i);
    op(seq_pkg::OP_SEND, seq_pkg::PH_DATA_OUT, sbuf[i]);
  endtask
  // Command offer, held until taken, then wait for the outcome
  task automatic run(logic [7:0] code, logic r);
    int k;
    int w;
    lat = 4'($random(seed)) & 4'h3;
    cc = code;
    cv = 1'b1;
    for (w = 0; rdy !== 1'b1 && w < 50; w++) @(negedge clk);
    @(negedge clk);
    cv = 1'b0;
    for (k = 0; done !== 1'b1 && rej !== 1'b1 && k < 400; k++) @(negedge clk);
    chk({17'h0, rej}, {17'h0, r});
    chk(18'(q.size()), 18'h0);
    chk({16'h0, w == 50, k == 400}, 18'h0);
    // Gap cycle so the next offer never rewrites the valid in this time step
    @(negedge clk);
  endtask
  // Every step leaving the buffer is compared in order
  always @(posedge clk)
  begin
    if (sdn) last_rx <= rxb;
    if (we) chk({2'b0, wa, wd}, {2'b0, rx_exp, last_rx});
    if (we) rx_exp <= rx_exp + 8'h01;
    // Remaining CDB bytes are known once the first byte names its group
    if (we && cdb)
    begin
      cdb = 1'b0;
      for (m = 1; m < ((last_rx[7:5] == 3'd5) ? seq_pkg::CDB_LEN_G5 :
           (last_rx[7:5] inside {3'd1, 3'd2}) ? seq_pkg::CDB_LEN_G1 : seq_pkg::CDB_LEN_G0); m++)
        op(seq_pkg::OP_RECV, seq_pkg::PH_COMMAND, 8'h00);
    end
    if (!rst && sv && sr)
    begin
      got = sdat;
      exp = q.size() ? q.pop_front() : '1;
      if (exp.kind != seq_pkg::OP_PHASE) got.phase = exp.phase;
      if (exp.kind != seq_pkg::OP_SEND) got.data = exp.data;
      chk(got, exp);
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #800000;
    err_total++;
    conclude();
  end
  // ==================
  // Scenarios
  initial
  begin
    for (int i = 0; i < 256; i++) sbuf[i] = 8'($random(seed));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    run(8'h1F, 1'b1);
    run(8'h2D, 1'b1);
    run(8'h3C, 1'b1);
    foreach (codes[i])
    begin
      c = codes[i];
      peer = 3'($random(seed));
      cnt = 8'h02 + (8'($random(seed)) & 8'h03);
      tail = (c > 8'h21 && c < 8'h26) || c == 8'h2A || c == 8'h2B;
      disc = tail ? !c[0] : (c == 8'h26 || c == 8'h2C);
      rx_exp = 8'h00;
      n = (c == 8'h24 || c == 8'h25 || c[3:1] == 3'b100) ? 0 : c == 8'h26 ? 2 :
          (c == 8'h21 || c == 8'h27 || c == 8'h2A || c == 8'h2B) ? cnt : 1;
      if (c < 8'h24 || c == 8'h2A || c == 8'h2B) op(seq_pkg::OP_RESEL, seq_pkg::PH_DATA_OUT, 8'h00);
      if (n > 0) op(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_IN, 8'h00);
      for (int j = 0; j < n; j++) sd(j);
      if (tail) op(seq_pkg::OP_PHASE, seq_pkg::PH_STATUS, 8'h00);
      if (tail) sd(n);
      if (tail) op(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_IN, 8'h00);
      if (tail) sd(n + 1);
      if (disc) op(seq_pkg::OP_DISC, seq_pkg::PH_DATA_OUT, 8'h00);
      if (c[3:1] == 3'b100) op(seq_pkg::OP_PHASE, c[0] ? seq_pkg::PH_MSG_OUT : seq_pkg::PH_COMMAND, 8'h00);
      for (int j = 0; j < cnt && c[3:1] == 3'b100; j++) op(seq_pkg::OP_RECV, seq_pkg::PH_DATA_OUT, 8'h00);
      run(c, 1'b0);
    end
    for (int i = 0; i < 12; i++)
    begin
      peer = 3'($random(seed));
      a = 8'($random(seed));
      co = a;
      rx_exp = a;
      case (i)
        0: op(seq_pkg::OP_RESEL, seq_pkg::PH_DATA_OUT, 8'h00);
        1: op(seq_pkg::OP_REQ_SET, seq_pkg::PH_DATA_OUT, 8'h00);
        2: op(seq_pkg::OP_REQ_CLR, seq_pkg::PH_DATA_OUT, 8'h00);
        3: op(seq_pkg::OP_DISC, seq_pkg::PH_DATA_OUT, 8'h00);
        4, 5: op(seq_pkg::OP_PHASE, seq_pkg::PH_DATA_IN, 8'h00);
        6, 7: op(seq_pkg::OP_PHASE, seq_pkg::PH_DATA_OUT, 8'h00);
        8: op(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_IN, 8'h00);
        9: op(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_OUT, 8'h00);
        10: op(seq_pkg::OP_PHASE, seq_pkg::PH_STATUS, 8'h00);
        default: op(seq_pkg::OP_PHASE, seq_pkg::PH_COMMAND, 8'h00);
      endcase
      if (i > 3 && i < 8) op(seq_pkg::OP_DATA, seq_pkg::PH_DATA_OUT, 8'h00);
      if (i == 8 || i == 10) sd(a);
      if (i == 9 || i == 11) op(seq_pkg::OP_RECV, seq_pkg::PH_DATA_OUT, 8'h00);
      cdb = (i == 11);
      run(8'h30 + 8'(i), 1'b0);
    end
    conclude();
  end
endmodule

// >>> verilog/seq_pkg.sv
// Purpose: Shared types, codes and step encoding of the target command sequencer
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Step lists are stored with the first step in the low slice

package seq_pkg;

  // ==========================================================================
  // Command code space
  // ==========================================================================
  localparam logic [7:0] SEQ_FIRST  = 8'h20;
  localparam logic [7:0] SEQ_LAST   = 8'h2C;
  localparam logic [7:0] DISC_FIRST = 8'h30;
  localparam logic [7:0] DISC_LAST  = 8'h3B;
  localparam logic [7:0] CMD_SEND_DATA_PIO = 8'h34;
  localparam logic [7:0] CMD_SEND_DATA_DMA = 8'h35;
  localparam logic [7:0] CMD_RECV_DATA_PIO = 8'h36;
  localparam logic [7:0] CMD_RECV_DATA_DMA = 8'h37;
  localparam logic [7:0] CMD_SEND_MSG      = 8'h38;
  localparam logic [7:0] CMD_RECV_MSG      = 8'h39;
  localparam logic [7:0] CMD_SEND_STATUS   = 8'h3A;
  localparam logic [7:0] CMD_RECV_CDB      = 8'h3B;

  // ==========================================================================
  // Step encoding
  // ==========================================================================
  typedef enum logic [3:0] {
    OP_END     = 4'b0000,
    OP_RESEL   = 4'b0001,
    OP_PHASE   = 4'b0010,
    OP_SEND    = 4'b0011,
    OP_RECV    = 4'b0100,
    OP_DISC    = 4'b0101,
    OP_REQ_SET = 4'b0110,
    OP_REQ_CLR = 4'b0111,
    OP_DATA    = 4'b1000
  } op_kind_t;

  // Bus phase as MSG, C/D, I/O
  typedef enum logic [2:0] {
    PH_DATA_OUT = 3'b000,
    PH_DATA_IN  = 3'b001,
    PH_COMMAND  = 3'b010,
    PH_STATUS   = 3'b011,
    PH_MSG_OUT  = 3'b110,
    PH_MSG_IN   = 3'b111
  } phase_t;

  typedef enum logic [1:0] {
    CNT_ONE = 2'b00,
    CNT_TWO = 2'b01,
    CNT_N   = 2'b10,
    CNT_CDB = 2'b11
  } cnt_sel_t;

  typedef struct packed {
    op_kind_t kind;
    phase_t   phase;
    cnt_sel_t cnt;
  } op_t;

  // One bus action handed to the phase engine
  typedef struct packed {
    op_kind_t    kind;
    phase_t      phase;
    logic [2:0]  peer_id;
    logic [7:0]  data;
  } bus_step_t;

  localparam int OP_W  = $bits(op_t);
  localparam int OPS   = 8;
  localparam int SEQ_W = OPS * OP_W;
  typedef logic [SEQ_W-1:0] seq_t;

  // CDB lengths by opcode group
  localparam logic [7:0] CDB_LEN_G0 = 8'h06;
  localparam logic [7:0] CDB_LEN_G1 = 8'h0A;
  localparam logic [7:0] CDB_LEN_G5 = 8'h0C;

  function automatic op_t mk(op_kind_t k, phase_t p, cnt_sel_t c);
    op_t o;
    o.kind  = k;
    o.phase = p;
    o.cnt   = c;
    return o;
  endfunction

endpackage

// >>> verilog/step_buffer.sv
// Purpose: Two-entry buffer between sequencer and bus phase engine
// Assumes: Same clock on both sides
// Notes:   Head entry is a flop so the output needs no read mux

`timescale 1ns/10ps

module step_buffer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  logic [W-1:0] ent0_r, ent0_nxt, ent1_r, ent1_nxt;
  logic         v0_r, v0_nxt, v1_r, v1_nxt;
  logic         push, pop;

  // ==========================================================================
  // Shift-down storage
  // ==========================================================================
  // Full only when both entries hold words; back-pressure reaches the source
  assign in_ready  = ~v1_r;
  assign out_valid = v0_r;
  assign out_data  = ent0_r;
  assign push      = in_valid & ~v1_r;
  assign pop       = v0_r & out_ready;

  // Next entry contents
  always_comb
  begin
    ent0_nxt = ent0_r;
    ent1_nxt = ent1_r;
    v0_nxt   = v0_r;
    v1_nxt   = v1_r;
    if (pop)
    begin
      if (v1_r)
      begin
        ent0_nxt = ent1_r;
        v1_nxt   = 1'b0;
      end
      else
      begin
        ent0_nxt = in_data;
        v0_nxt   = push;
      end
    end
    else if (push)
    begin
      if (v0_r)
      begin
        ent1_nxt = in_data;
        v1_nxt   = 1'b1;
      end
      else
      begin
        ent0_nxt = in_data;
        v0_nxt   = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ent0_r <= '0;
      ent1_r <= '0;
      v0_r   <= 1'b0;
      v1_r   <= 1'b0;
    end
    else
    begin
      ent0_r <= ent0_nxt;
      ent1_r <= ent1_nxt;
      v0_r   <= v0_nxt;
      v1_r   <= v1_nxt;
    end
  end

endmodule

// >>> verilog/target_cmd_sequencer.sv
// Purpose: Decode target command codes and walk them as ordered bus steps
// Assumes: Send buffer read port has one cycle of latency
// Notes:   One step is outstanding at a time; the engine reports completion

`timescale 1ns/10ps

// Behaviour
// - Codes 0x20..0x2C with bits 7:6=0, 5=1, 4=0 are sequential commands
// - Codes 0x30..0x3B with bits 5:4 set are discrete bus actions
// - Sequential commands take no operand; host preloads buffer and registers
// - Program 0x38 takes address of message byte to send
// - Program 0x39 takes address where received message is written
// - Program 0x3A takes address of status byte to send
// - Program 0x3B takes address where received CDB is written
// - 0x20: reselect, message-in, send one message byte
// - 0x21: reselect, message-in, send byte-count message bytes
// - 0x22/0x23: reselect, one message, then terminate or link-terminate
// - 0x24: status byte, message byte, then disconnect
// - 0x25: status byte then message byte, no disconnect
// - 0x26: message-in, two-byte message, then disconnect
// - 0x27: message-in, send byte-count message bytes
// - 0x2A/0x2B N-byte terminate variants, 0x2C second disconnect sequence
// - Data send enters data-in, data receive enters data-out first
module target_cmd_sequencer #(
  parameter int AW = 8,
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Command from host logic
  input  wire logic                  cmd_valid,
  input  wire logic [7:0]            cmd_code,
  input  wire logic [AW-1:0]         cmd_operand,
  output logic                       cmd_ready,
  // Preloaded setup values
  input  wire logic [CW-1:0]         transfer_byte_count,
  input  wire logic [2:0]            peer_id_select,
  // Send buffer read port
  output logic                       sbuf_rd_en,
  output logic [AW-1:0]              sbuf_rd_addr,
  input  wire logic [7:0]            sbuf_rd_data,
  // Received byte write port
  output logic                       rx_wr_en,
  output logic [AW-1:0]              rx_wr_addr,
  output logic [7:0]                 rx_wr_data,
  // Steps toward the bus phase engine
  output logic                       step_valid,
  output seq_pkg::bus_step_t         step_data,
  input  wire logic                  step_ready,
  input  wire logic                  step_done,
  input  wire logic [7:0]            step_rx_byte,
  // Status
  output logic                       busy,
  output logic                       cmd_done,
  output logic                       cmd_reject
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_READ  = 3'b010,
    ST_CATCH = 3'b011,
    ST_ISSUE = 3'b100,
    ST_WAIT  = 3'b101
  } state_t;

  state_t             state_r, state_nxt;
  seq_pkg::seq_t      seq_r, seq_nxt;
  logic [CW-1:0]      left_r, left_nxt;
  logic [AW-1:0]      sptr_r, sptr_nxt, rptr_r, rptr_nxt;
  logic [7:0]         byte_r, byte_nxt;
  logic               first_r, first_nxt;
  logic               rd_en_r, rd_en_nxt, wr_en_r, wr_en_nxt;
  logic [AW-1:0]      rd_addr_r, rd_addr_nxt, wr_addr_r, wr_addr_nxt;
  logic [7:0]         wr_data_r, wr_data_nxt;
  logic               busy_r, busy_nxt, done_r, done_nxt, rej_r, rej_nxt;
  logic               ready_r, ready_nxt;
  seq_pkg::op_t       cur;
  seq_pkg::bus_step_t push_step;
  logic               push, buf_ready, accept, is_seq, is_disc;

  // ==========================================================================
  // Decode
  // ==========================================================================
  assign accept  = cmd_valid & ready_r;
  // Code ranges come from bit fields, low nibble bounds the populated codes
  assign is_seq  = (cmd_code[7:4] == 4'h2) && (cmd_code <= seq_pkg::SEQ_LAST);
  assign is_disc = (cmd_code[7:4] == 4'h3) && (cmd_code <= seq_pkg::DISC_LAST);
  assign cur     = seq_pkg::op_t'(seq_r[seq_pkg::OP_W-1:0]);

  // Step list per code, written last step first
  function automatic seq_pkg::seq_t table_of(logic [7:0] c);
    seq_pkg::op_t rs, mi, st, s1, s2, sn, dc;
    rs = seq_pkg::mk(seq_pkg::OP_RESEL, seq_pkg::PH_MSG_IN, seq_pkg::CNT_ONE);
    mi = seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_IN, seq_pkg::CNT_ONE);
    st = seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_STATUS, seq_pkg::CNT_ONE);
    s1 = seq_pkg::mk(seq_pkg::OP_SEND, seq_pkg::PH_MSG_IN, seq_pkg::CNT_ONE);
    s2 = seq_pkg::mk(seq_pkg::OP_SEND, seq_pkg::PH_MSG_IN, seq_pkg::CNT_TWO);
    sn = seq_pkg::mk(seq_pkg::OP_SEND, seq_pkg::PH_MSG_IN, seq_pkg::CNT_N);
    dc = seq_pkg::mk(seq_pkg::OP_DISC, seq_pkg::PH_MSG_IN, seq_pkg::CNT_ONE);
    case (c)
      8'h20: table_of = seq_pkg::seq_t'({s1, mi, rs});
      8'h21: table_of = seq_pkg::seq_t'({sn, mi, rs});
      8'h22: table_of = seq_pkg::seq_t'({dc, s1, mi, s1, st, s1, mi, rs});
      8'h23: table_of = seq_pkg::seq_t'({s1, mi, s1, st, s1, mi, rs});
      8'h24: table_of = seq_pkg::seq_t'({dc, s1, mi, s1, st});
      8'h25: table_of = seq_pkg::seq_t'({s1, mi, s1, st});
      8'h26: table_of = seq_pkg::seq_t'({dc, s2, mi});
      8'h27: table_of = seq_pkg::seq_t'({sn, mi});
      8'h28: table_of = seq_pkg::seq_t'({seq_pkg::mk(seq_pkg::OP_RECV, seq_pkg::PH_COMMAND, seq_pkg::CNT_N),
                                          seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_COMMAND, seq_pkg::CNT_ONE)});
      8'h29: table_of = seq_pkg::seq_t'({seq_pkg::mk(seq_pkg::OP_RECV, seq_pkg::PH_MSG_OUT, seq_pkg::CNT_N),
                                          seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_OUT, seq_pkg::CNT_ONE)});
      8'h2A: table_of = seq_pkg::seq_t'({dc, s1, mi, s1, st, sn, mi, rs});
      8'h2B: table_of = seq_pkg::seq_t'({s1, mi, s1, st, sn, mi, rs});
      8'h2C: table_of = seq_pkg::seq_t'({dc, s1, mi});
      8'h30: table_of = seq_pkg::seq_t'(rs);
      8'h31: table_of = seq_pkg::seq_t'(seq_pkg::mk(seq_pkg::OP_REQ_SET, seq_pkg::PH_MSG_IN, seq_pkg::CNT_ONE));
      8'h32: table_of = seq_pkg::seq_t'(seq_pkg::mk(seq_pkg::OP_REQ_CLR, seq_pkg::PH_MSG_IN, seq_pkg::CNT_ONE));
      8'h33: table_of = seq_pkg::seq_t'(dc);
      // Data phase first, then one engine-run transfer
      8'h34, 8'h35: table_of = seq_pkg::seq_t'({
        seq_pkg::mk(seq_pkg::OP_DATA, seq_pkg::PH_DATA_IN, seq_pkg::CNT_ONE),
        seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_DATA_IN, seq_pkg::CNT_ONE)});
      8'h36, 8'h37: table_of = seq_pkg::seq_t'({
        seq_pkg::mk(seq_pkg::OP_DATA, seq_pkg::PH_DATA_OUT, seq_pkg::CNT_ONE),
        seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_DATA_OUT, seq_pkg::CNT_ONE)});
      8'h38: table_of = seq_pkg::seq_t'({s1, mi});
      8'h39: table_of = seq_pkg::seq_t'({seq_pkg::mk(seq_pkg::OP_RECV, seq_pkg::PH_MSG_OUT, seq_pkg::CNT_ONE),
                                          seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_MSG_OUT, seq_pkg::CNT_ONE)});
      8'h3A: table_of = seq_pkg::seq_t'({seq_pkg::mk(seq_pkg::OP_SEND, seq_pkg::PH_STATUS, seq_pkg::CNT_ONE), st});
      8'h3B: table_of = seq_pkg::seq_t'({seq_pkg::mk(seq_pkg::OP_RECV, seq_pkg::PH_COMMAND, seq_pkg::CNT_CDB),
                                          seq_pkg::mk(seq_pkg::OP_PHASE, seq_pkg::PH_COMMAND, seq_pkg::CNT_ONE)});
      default: table_of = '0;
    endcase
  endfunction

  // CDB length from the opcode group of its first byte
  function automatic logic [7:0] cdb_len(logic [7:0] op);
    case (op[7:5])
      3'd1, 3'd2: cdb_len = seq_pkg::CDB_LEN_G1;
      3'd5:       cdb_len = seq_pkg::CDB_LEN_G5;
      default:    cdb_len = seq_pkg::CDB_LEN_G0;
    endcase
  endfunction

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign push = (state_r == ST_ISSUE) && buf_ready;
  always_comb
  begin
    push_step.kind    = cur.kind;
    push_step.phase   = cur.phase;
    push_step.peer_id = peer_id_select;
    push_step.data    = byte_r;
  end

  // Next state and datapath; one step outstanding keeps bus phases ordered
  always_comb
  begin
    state_nxt   = state_r;
    seq_nxt     = seq_r;
    left_nxt    = left_r;
    sptr_nxt    = sptr_r;
    rptr_nxt    = rptr_r;
    byte_nxt    = byte_r;
    first_nxt   = first_r;
    rd_en_nxt   = 1'b0;
    rd_addr_nxt = rd_addr_r;
    wr_en_nxt   = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    done_nxt    = 1'b0;
    rej_nxt     = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (accept)
        begin
          if (is_seq || is_disc)
          begin
            seq_nxt   = table_of(cmd_code);
            state_nxt = ST_LOAD;
            // Sequential codes start at buffer origin; discrete ones use operand
            sptr_nxt  = is_seq ? '0 : cmd_operand;
            rptr_nxt  = is_seq ? '0 : cmd_operand;
          end
          else
          begin
            rej_nxt = 1'b1;
          end
        end
      end
      ST_LOAD:
      begin
        first_nxt = 1'b1;
        case (cur.cnt)
          seq_pkg::CNT_TWO: left_nxt = CW'(2);
          // Byte count of one is not allowed by the host; zero wraps the count and sends 256 bytes at CW of 8
          seq_pkg::CNT_N:   left_nxt = transfer_byte_count;
          default:          left_nxt = CW'(1);
        endcase
        if (cur.kind == seq_pkg::OP_END)
        begin
          done_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end
        else if (cur.kind == seq_pkg::OP_SEND)
        begin
          rd_en_nxt   = 1'b1;
          rd_addr_nxt = sptr_r;
          state_nxt   = ST_READ;
        end
        else
        begin
          state_nxt = ST_ISSUE;
        end
      end
      ST_READ:  state_nxt = ST_CATCH;
      ST_CATCH:
      begin
        byte_nxt  = sbuf_rd_data;
        state_nxt = ST_ISSUE;
      end
      ST_ISSUE: if (buf_ready) state_nxt = ST_WAIT;
      ST_WAIT:
      begin
        if (step_done)
        begin
          first_nxt = 1'b0;
          left_nxt  = left_r - CW'(1);
          if (cur.kind == seq_pkg::OP_SEND)
            sptr_nxt = sptr_r + AW'(1);
          if (cur.kind == seq_pkg::OP_RECV)
          begin
            wr_en_nxt   = 1'b1;
            wr_addr_nxt = rptr_r;
            wr_data_nxt = step_rx_byte;
            rptr_nxt    = rptr_r + AW'(1);
            if (cur.cnt == seq_pkg::CNT_CDB && first_r)
              left_nxt = CW'(cdb_len(step_rx_byte) - 8'h01);
          end
          if ((cur.kind == seq_pkg::OP_SEND || cur.kind == seq_pkg::OP_RECV) && left_nxt != '0)
          begin
            rd_en_nxt   = (cur.kind == seq_pkg::OP_SEND);
            rd_addr_nxt = sptr_nxt;
            state_nxt   = (cur.kind == seq_pkg::OP_SEND) ? ST_READ : ST_ISSUE;
          end
          else
          begin
            // Advance to the next listed step only after completion
            seq_nxt   = seq_r >> seq_pkg::OP_W;
            state_nxt = ST_LOAD;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    busy_nxt  = (state_nxt != ST_IDLE);
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r   <= ST_IDLE;
      seq_r     <= '0;
      left_r    <= '0;
      sptr_r    <= '0;
      rptr_r    <= '0;
      byte_r    <= '0;
      first_r   <= 1'b0;
      rd_en_r   <= 1'b0;
      rd_addr_r <= '0;
      wr_en_r   <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      rej_r     <= 1'b0;
      ready_r   <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      seq_r     <= seq_nxt;
      left_r    <= left_nxt;
      sptr_r    <= sptr_nxt;
      rptr_r    <= rptr_nxt;
      byte_r    <= byte_nxt;
      first_r   <= first_nxt;
      rd_en_r   <= rd_en_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_en_r   <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      busy_r    <= busy_nxt;
      done_r    <= done_nxt;
      rej_r     <= rej_nxt;
      ready_r   <= ready_nxt;
    end
  end

  // Output buffer absorbs an engine stall without losing a step
  step_buffer #(.W($bits(seq_pkg::bus_step_t))) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_data   (push_step),
    .in_ready  (buf_ready),
    .out_valid (step_valid),
    .out_data  (step_data),
    .out_ready (step_ready)
  );

  assign cmd_ready    = ready_r;
  assign sbuf_rd_en   = rd_en_r;
  assign sbuf_rd_addr = rd_addr_r;
  assign rx_wr_en     = wr_en_r;
  assign rx_wr_addr   = wr_addr_r;
  assign rx_wr_data   = wr_data_r;
  assign busy         = busy_r;
  assign cmd_done     = done_r;
  assign cmd_reject   = rej_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_SEQ_ACCEPT: assert property (@(posedge clk) disable iff (rst)
    accept && cmd_code >= 8'h20 && cmd_code <= 8'h2C |=> busy && !cmd_reject)
    else $error("sequential code not accepted");
  AST_DISC_ACCEPT: assert property (@(posedge clk) disable iff (rst)
    accept && cmd_code >= 8'h30 && cmd_code <= 8'h3B |=> busy && !cmd_reject)
    else $error("discrete code not accepted");
  AST_BAD_REJECT: assert property (@(posedge clk) disable iff (rst)
    accept && !(cmd_code inside {[8'h20:8'h2C], [8'h30:8'h3B]}) |=> cmd_reject && !busy)
    else $error("undefined code not rejected");
  AST_SEQ_NO_OPERAND: assert property (@(posedge clk) disable iff (rst)
    accept && is_seq |=> sptr_r == '0 && rptr_r == '0)
    else $error("sequential command used operand");
  AST_SEND_MSG_ADDR: assert property (@(posedge clk) disable iff (rst)
    accept && cmd_code == 8'h38 |=> sptr_r == $past(cmd_operand))
    else $error("message byte not read at operand");
  AST_RECV_MSG_ADDR: assert property (@(posedge clk) disable iff (rst)
    accept && cmd_code == 8'h39 |=> rptr_r == $past(cmd_operand))
    else $error("message write address wrong");
  AST_STATUS_ADDR: assert property (@(posedge clk) disable iff (rst)
    accept && cmd_code == 8'h3A |=> sptr_r == $past(cmd_operand))
    else $error("status read address wrong");
  AST_CDB_ADDR: assert property (@(posedge clk) disable iff (rst)
    rx_wr_en && $past(state_r == ST_WAIT && first_r && cur.cnt == seq_pkg::CNT_CDB) |-> rx_wr_addr == $past(rptr_r))
    else $error("first CDB byte misplaced");
  AST_DATA_PHASE_FIRST: assert property (@(posedge clk) disable iff (rst)
    accept && cmd_code inside {[8'h34:8'h37]} |=> ##1 push && push_step.kind == seq_pkg::OP_PHASE
      && push_step.phase == ($past(cmd_code[1], 2) ? seq_pkg::PH_DATA_OUT : seq_pkg::PH_DATA_IN))
    else $error("data phase not entered first");
  AST_HOLD_UNTIL_DONE: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_WAIT && !step_done |=> state_r == ST_WAIT && !push)
    else $error("step advanced before completion");
  AST_DISC_LAST: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_WAIT && step_done && cur.kind == seq_pkg::OP_DISC |=> state_r == ST_LOAD
      && cur.kind == seq_pkg::OP_END)
    else $error("steps follow disconnect");

endmodule
